// ==== hdl/ysb_bus_yield.sv ====
// Bus yield arbitration and serial bit input/output sequencer.
// Assumes the core presents one memory or serial request at a time and
// holds it until the matching done pulse; the bus has external pull-ups.
//
// Overview of operation
// - Yield only between memory cycles, never inside.
// - Yield raises grant, releases all bus drivers.
// - Request released: drop grant, resume bus.
// - Serial op interrupted: one extra address cycle.
// - Output bit: address on A0-A11 (A12-A14 low), value out.
// - Strobe pulse in second cycle of bit.
// - Repeat per bit for full field length.
// - Input bit: address out, sample input line.
// - Bit address is base plus signed displacement.
// - Reset suppresses write and serial strobes.
`timescale 1ns/100ps
module ysb_bus_yield
(
	// Clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// Core side
	input  wire ysb_pkg::ysb_mem_req_type      mem_req,
	input  wire ysb_pkg::ysb_ser_req_type      ser_req,
	output logic                               mem_done,
	output logic                               ser_done,
	output logic [ysb_pkg::DATA_W-1:0]         ser_in_bits,
	// Bus pins
	input  wire logic                          bus_yield_req_n,
	output logic                               bus_yield_grant,
	output logic                               memory_cycle_strobe_n,
	output logic                               memory_cycle_strobe_oe_n,
	output logic                               bus_read_direction,
	output logic                               bus_read_direction_oe_n,
	output logic                               write_strobe_n,
	output logic                               write_strobe_oe_n,
	output logic [ysb_pkg::ADDR_W-1:0]         addr_out,
	output logic                               addr_oe_n,
	output logic [ysb_pkg::DATA_W-1:0]         data_out,
	output logic                               data_oe_n,
	// Serial bit pins
	output logic                               serial_io_out_bit,
	output logic                               serial_io_bit_strobe,
	input  wire logic                          serial_io_in_bit
);
	// ==========================================================
	// State
	typedef struct packed
	{
		ysb_pkg::ysb_state_type             state;
		ysb_pkg::ysb_state_type             resume;
		logic                               in_mem;
		logic                               grant;
		logic                               mem_strobe_n;
		logic                               read_dir;
		logic                               wr_n;
		logic                               bus_oe_n;
		logic                               data_oe_n;
		logic [ysb_pkg::ADDR_W-1:0]         addr;
		logic [ysb_pkg::DATA_W-1:0]         data;
		logic                               mem_done;
		logic                               ser_done;
		logic                               ser_active;
		logic [ysb_pkg::SER_ADDR_W-1:0]     bit_addr;
		logic [ysb_pkg::COUNT_W-1:0]        bit_idx;
		logic [ysb_pkg::DATA_W-1:0]         in_bits;
		logic                               out_bit;
		logic                               strobe;
		logic                               cap_pend;
		logic [3:0]                         cap_idx;
		logic                               done_pend;
	} ysb_regs_type;

	ysb_regs_type cur;
	ysb_regs_type next_cur;
	logic         req_n_sync;
	logic         in_bit_sync;
	logic [ysb_pkg::SER_ADDR_W-1:0] start_addr;
	logic [ysb_pkg::COUNT_W-1:0]    last_idx;

	// ==========================================================
	// Input synchronisers
	ysb_sync u_req_sync
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.rst_value (1'b1),
		.async_in  (bus_yield_req_n),
		.sync_out  (req_n_sync)
	);

	ysb_sync u_in_sync
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.rst_value (1'b1),
		.async_in  (serial_io_in_bit),
		.sync_out  (in_bit_sync)
	);

	// Base bits 3..14 plus sign-extended displacement
	assign start_addr = ser_req.base_reg[ysb_pkg::BASE_MSB:ysb_pkg::BASE_LSB]
		+ {{(ysb_pkg::SER_ADDR_W-ysb_pkg::DISP_W){ser_req.disp[7]}},
		ser_req.disp};
	// Field length 0 means a full 16-bit field
	assign last_idx = (ser_req.count == 5'h00) ? 5'h0f : 5'(ser_req.count - 5'h01);

	// ==========================================================
	// Next state
	always_comb
	begin
		next_cur          = cur;
		next_cur.mem_done = 1'b0;
		next_cur.ser_done = 1'b0;
		next_cur.strobe   = 1'b0;
		next_cur.cap_pend  = 1'b0;
		next_cur.done_pend = 1'b0;
		// Input bit leaves the synchroniser one cycle after its strobe cycle
		if (cur.cap_pend)
			next_cur.in_bits[cur.cap_idx] = in_bit_sync;
		if (cur.done_pend)
			next_cur.ser_done = 1'b1;
		case (cur.state)
			ysb_pkg::YSB_IDLE, ysb_pkg::YSB_ADDR, ysb_pkg::YSB_STROBE,
			ysb_pkg::YSB_READD:
			begin
				if (cur.in_mem)
				begin
					// Memory cycle runs to completion first
					next_cur.in_mem       = 1'b0;
					next_cur.mem_strobe_n = 1'b1;
					next_cur.read_dir     = 1'b0;
					next_cur.wr_n         = 1'b1;
					next_cur.data_oe_n    = 1'b1;
					next_cur.mem_done     = 1'b1;
				end
				// A strobed bit finishes before the bus is yielded
				else if (!req_n_sync && cur.state != ysb_pkg::YSB_STROBE)
				begin
					next_cur.resume    = cur.state;
					next_cur.state     = ysb_pkg::YSB_YIELD;
					next_cur.grant     = 1'b1;
					next_cur.bus_oe_n  = 1'b1;
					next_cur.data_oe_n = 1'b1;
				end
				else
				begin
					case (cur.state)
						ysb_pkg::YSB_IDLE:
						begin
							if (ser_req.valid && !cur.ser_done && !cur.done_pend)
							begin
								next_cur.bit_addr = start_addr;
								next_cur.bit_idx  = 5'h00;
								next_cur.in_bits  = 16'h0000;
								next_cur.out_bit  = ser_req.out_bits[0];
								next_cur.addr     = {3'h0, start_addr};
								next_cur.state    = ysb_pkg::YSB_ADDR;
							end
							else if (mem_req.valid && !cur.mem_done)
							begin
								next_cur.in_mem       = 1'b1;
								next_cur.addr         = mem_req.addr;
								next_cur.mem_strobe_n = 1'b0;
								next_cur.read_dir     = !mem_req.write;
								next_cur.wr_n         = !mem_req.write;
								next_cur.data         = mem_req.wdata;
								next_cur.data_oe_n    = !mem_req.write;
							end
						end
						ysb_pkg::YSB_ADDR, ysb_pkg::YSB_READD:
						begin
							next_cur.state  = ysb_pkg::YSB_STROBE;
							next_cur.strobe = ser_req.output_dir;
						end
						ysb_pkg::YSB_STROBE:
						begin
							if (!ser_req.output_dir)
							begin
								next_cur.cap_pend = 1'b1;
								next_cur.cap_idx  = cur.bit_idx[3:0];
							end
							if (cur.bit_idx == last_idx)
							begin
								next_cur.done_pend = 1'b1;
								next_cur.state    = ysb_pkg::YSB_IDLE;
							end
							else
							begin
								next_cur.bit_idx  = 5'(cur.bit_idx + 5'h01);
								next_cur.bit_addr = 12'(cur.bit_addr + 12'h001);
								next_cur.addr     = {3'h0, 12'(cur.bit_addr + 12'h001)};
								next_cur.out_bit  = ser_req.out_bits[4'(cur.bit_idx + 5'h01)];
								next_cur.state    = ysb_pkg::YSB_ADDR;
							end
						end
						default: next_cur.state = ysb_pkg::YSB_IDLE;
					endcase
				end
			end
			ysb_pkg::YSB_YIELD:
			begin
				if (req_n_sync)
				begin
					next_cur.grant    = 1'b0;
					next_cur.bus_oe_n = 1'b0;
					// Serial op re-drives its address for one extra cycle
					next_cur.state = (cur.resume == ysb_pkg::YSB_IDLE) ?
						ysb_pkg::YSB_IDLE : ysb_pkg::YSB_READD;
				end
			end
			default: next_cur.state = ysb_pkg::YSB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur              <= '0;
			cur.state        <= ysb_pkg::YSB_IDLE;
			cur.resume       <= ysb_pkg::YSB_IDLE;
			cur.mem_strobe_n <= 1'b1;
			cur.wr_n         <= 1'b1;
			cur.data_oe_n    <= 1'b1;
			cur.addr         <= ysb_pkg::ADDR_RST;
			cur.data         <= ysb_pkg::DATA_RST;
			cur.strobe       <= 1'b0;
		end
		else
			cur <= next_cur;
	end

	// ==========================================================
	// Outputs
	assign bus_yield_grant          = cur.grant;
	assign memory_cycle_strobe_n    = cur.mem_strobe_n;
	assign memory_cycle_strobe_oe_n = cur.bus_oe_n;
	assign bus_read_direction       = cur.read_dir;
	assign bus_read_direction_oe_n  = cur.bus_oe_n;
	assign write_strobe_n           = cur.wr_n;
	assign write_strobe_oe_n        = cur.bus_oe_n;
	assign addr_out                 = cur.addr;
	assign addr_oe_n                = cur.bus_oe_n;
	assign data_out                 = cur.data;
	assign data_oe_n                = cur.data_oe_n;
	assign serial_io_out_bit        = cur.out_bit;
	assign serial_io_bit_strobe     = cur.strobe;
	assign mem_done                 = cur.mem_done;
	assign ser_done                 = cur.ser_done;
	assign ser_in_bits              = cur.in_bits;

	// ==========================================================
	// Assertions
	sequence s_released;
		$rose(req_n_sync) && cur.state == ysb_pkg::YSB_YIELD;
	endsequence

	property p_no_yield_in_mem;
		@(posedge sys_clk) disable iff (!rst_n)
		cur.in_mem |=> !cur.grant;
	endproperty
	a_no_yield_in_mem: assert property (p_no_yield_in_mem)
		else $error("grant raised inside memory cycle");

	property p_grant_release;
		@(posedge sys_clk) disable iff (!rst_n)
		cur.grant |-> addr_oe_n && data_oe_n && write_strobe_oe_n;
	endproperty
	a_grant_release: assert property (p_grant_release)
		else $error("bus driven while yielded");

	property p_grant_drop;
		@(posedge sys_clk) disable iff (!rst_n)
		(cur.state == ysb_pkg::YSB_YIELD && req_n_sync) |=> !cur.grant;
	endproperty
	a_grant_drop: assert property (p_grant_drop)
		else $error("grant not dropped");

	property p_readdress;
		@(posedge sys_clk) disable iff (!rst_n)
		(cur.state == ysb_pkg::YSB_YIELD && req_n_sync &&
		cur.resume != ysb_pkg::YSB_IDLE) |=> !serial_io_bit_strobe ##1
		cur.state == ysb_pkg::YSB_STROBE;
	endproperty
	a_readdress: assert property (p_readdress)
		else $error("no extra address cycle after yield");

	property p_strobe_second;
		@(posedge sys_clk) disable iff (!rst_n)
		serial_io_bit_strobe |-> $past(cur.state) != ysb_pkg::YSB_STROBE
		&& cur.state == ysb_pkg::YSB_STROBE && ser_req.output_dir;
	endproperty
	a_strobe_second: assert property (p_strobe_second)
		else $error("strobe outside second bit cycle");

	property p_strobe_one;
		@(posedge sys_clk) disable iff (!rst_n)
		serial_io_bit_strobe |=> !serial_io_bit_strobe;
	endproperty
	a_strobe_one: assert property (p_strobe_one)
		else $error("strobe longer than one cycle");

	property p_addr_step;
		@(posedge sys_clk) disable iff (!rst_n)
		(cur.state == ysb_pkg::YSB_STROBE && !cur.grant &&
		req_n_sync && cur.bit_idx != last_idx) |=>
		addr_out[ysb_pkg::SER_ADDR_W-1:0] == 12'($past(cur.bit_addr) + 12'h001);
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("bit address did not advance");

	property p_done_bound;
		@(posedge sys_clk) disable iff (!rst_n)
		(cur.state == ysb_pkg::YSB_STROBE && cur.bit_idx == last_idx &&
		req_n_sync) |-> ##2 ser_done;
	endproperty
	a_done_bound: assert property (p_done_bound)
		else $error("serial field did not finish");

	property p_grant_edge;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(cur.grant) |-> !$past(req_n_sync);
	endproperty
	a_grant_edge: assert property (p_grant_edge)
		else $error("grant without sampled request");

	property p_leave;
		@(posedge sys_clk) disable iff (!rst_n)
		s_released |=> !addr_oe_n;
	endproperty
	a_leave: assert property (p_leave)
		else $error("bus not resumed");

endmodule : ysb_bus_yield

// ==== hdl/ysb_pkg.sv ====
// Shared types and constants for the bus yield and serial bit unit.
// Assumes a single 100 MHz processor clock.
package ysb_pkg;

	// ==========================================================
	// Field layout
	localparam int ADDR_W       = 15;
	localparam int DATA_W       = 16;
	localparam int SER_ADDR_W   = 12;
	localparam int SER_ADDR_LSB = 3;
	localparam int DISP_W       = 8;
	localparam int COUNT_W      = 5;
	localparam int BASE_LSB     = 3;
	localparam int BASE_MSB     = 14;

	// ==========================================================
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 15'h7fff;
	localparam logic [DATA_W-1:0] DATA_RST = 16'hffff;

	// ==========================================================
	// Serial sequencer states
	typedef enum logic [2:0]
	{
		YSB_IDLE   = 3'b000,
		YSB_ADDR   = 3'b001,
		YSB_STROBE = 3'b010,
		YSB_READD  = 3'b011,
		YSB_YIELD  = 3'b100
	} ysb_state_type;

	// Core memory request
	typedef struct packed
	{
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ysb_mem_req_type;

	// Core serial I/O request
	typedef struct packed
	{
		logic               valid;
		logic               output_dir;
		logic [DATA_W-1:0]  base_reg;
		logic [DISP_W-1:0]  disp;
		logic [COUNT_W-1:0] count;
		logic [DATA_W-1:0]  out_bits;
	} ysb_ser_req_type;

endpackage : ysb_pkg

// ==== hdl/ysb_sync.sv ====
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/100ps
module ysb_sync
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic rst_value,
	// Level
	input  wire logic async_in,
	output logic      sync_out
);
	logic stage_one;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage_one <= 1'b1;
			sync_out  <= 1'b1;
		end
		else
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

	logic unused_rst_value;
	assign unused_rst_value = rst_value;

endmodule : ysb_sync

// ==== verification/ysb_far_model.sv ====
// Far side model: a DMA master that borrows the bus and serial peripherals.
// Assumes the bench pulses dma_go for one cycle and reads the records back.
`timescale 1ns/100ps
module ysb_far_model
#(
	parameter int HOLD_CYC = 4
)
(
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         rst_n,
	// Bench control
	input  wire logic                         dma_go,
	output logic                              dma_busy,
	// Bus pins
	output logic                              bus_yield_req_n,
	input  wire logic                         bus_yield_grant,
	input  wire logic [ysb_pkg::ADDR_W-1:0]   addr_out,
	input  wire logic                         addr_oe_n,
	// Serial bit pins
	input  wire logic                         serial_io_out_bit,
	input  wire logic                         serial_io_bit_strobe,
	output logic                              serial_io_in_bit
);
	logic [7:0]    held;
	logic          out_mem [4096];
	int unsigned   strobes = 0;
	logic [ysb_pkg::ADDR_W-1:0] bus_addr;

	// Released address lines float up to the pull-up level
	assign bus_addr = addr_oe_n ? {ysb_pkg::ADDR_W{1'b1}} : addr_out;

	// ==========================================================
	// Bus borrower: ask, wait for grant, use, give back
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_yield_req_n <= 1'b1;
			dma_busy        <= 1'b0;
			held            <= 8'h00;
		end
		else if (!dma_busy && dma_go)
		begin
			dma_busy        <= 1'b1;
			bus_yield_req_n <= 1'b0;
			held            <= 8'h00;
		end
		else if (dma_busy && !bus_yield_req_n && bus_yield_grant)
		begin
			held <= held + 8'h01;
			if (held == 8'(HOLD_CYC))
				bus_yield_req_n <= 1'b1;
		end
		else if (dma_busy && bus_yield_req_n && !bus_yield_grant)
			dma_busy <= 1'b0;
	end

	// ==========================================================
	// Peripherals: each address answers its own bit, latch strobed bits
	assign serial_io_in_bit = bus_addr[0] ^ bus_addr[2];

	always @(posedge sys_clk)
	begin
		if (serial_io_bit_strobe === 1'b1)
		begin
			out_mem[bus_addr[11:0]] <= serial_io_out_bit;
			strobes <= strobes + 1;
		end
	end
endmodule : ysb_far_model

// ==== verification/ysb_bus_yield_tb.sv ====
// Self-checking bench for the bus yield and serial bit unit.
// Assumes ysb_far_model stands on the pin side; drives at falling edges.
`timescale 1ns/100ps
module ysb_bus_yield_tb;
	logic                       sys_clk;
	logic                       rst_n;
	ysb_pkg::ysb_mem_req_type   mem_req;
	ysb_pkg::ysb_ser_req_type   ser_req;
	logic                       mem_done, ser_done, dma_go, dma_busy;
	logic [ysb_pkg::DATA_W-1:0] ser_in_bits, data_out;
	logic [ysb_pkg::ADDR_W-1:0] addr_out;
	logic                       req_n, grant, mcs_n, mcs_oe_n, rd, rd_oe_n;
	logic                       wr_n, wr_oe_n, addr_oe_n, data_oe_n;
	logic                       s_out, s_strobe, s_in;
	int                         miscompares = 0;
	int                         samples_checked = 0;

	ysb_bus_yield DUT
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req),
		.ser_req(ser_req), .mem_done(mem_done), .ser_done(ser_done),
		.ser_in_bits(ser_in_bits), .bus_yield_req_n(req_n),
		.bus_yield_grant(grant), .memory_cycle_strobe_n(mcs_n),
		.memory_cycle_strobe_oe_n(mcs_oe_n), .bus_read_direction(rd),
		.bus_read_direction_oe_n(rd_oe_n), .write_strobe_n(wr_n),
		.write_strobe_oe_n(wr_oe_n), .addr_out(addr_out),
		.addr_oe_n(addr_oe_n), .data_out(data_out), .data_oe_n(data_oe_n),
		.serial_io_out_bit(s_out), .serial_io_bit_strobe(s_strobe),
		.serial_io_in_bit(s_in)
	);

	ysb_far_model far
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .dma_go(dma_go),
		.dma_busy(dma_busy), .bus_yield_req_n(req_n),
		.bus_yield_grant(grant), .addr_out(addr_out),
		.addr_oe_n(addr_oe_n),
		.serial_io_out_bit(s_out), .serial_io_bit_strobe(s_strobe),
		.serial_io_in_bit(s_in)
	);

	// ==========================================================
	// Helpers
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("BAD t=%0t %s", $time, msg);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Scenarios
	task automatic ser_run(input logic dir, input logic [15:0] base,
		input logic [7:0] disp, input logic [4:0] cnt,
		input logic [15:0] bits, input logic dma);
		int          n;
		int          nb;
		int unsigned s0;
		logic [11:0] start;
		logic [11:0] a;
		logic        prev_oe;
		nb = (cnt == 5'h00) ? 16 : int'(cnt);
		start = base[ysb_pkg::BASE_MSB:ysb_pkg::BASE_LSB]
			+ {{4{disp[7]}}, disp};
		s0 = far.strobes;
		ser_req = '{1'b1, dir, base, disp, cnt, bits};
		n = 0;
		prev_oe = addr_oe_n;
		while (ser_done !== 1'b1 && n < 200)
		begin
			@(negedge sys_clk);
			n++;
			dma_go = dma && (n == 3);
			if (s_strobe === 1'b1)
				check(prev_oe === 1'b0, "strobe without address setup");
			prev_oe = addr_oe_n;
		end
		ser_req.valid = 1'b0;
		if (dma)
			check(n > 2 * nb + 2 && n < 200, "yielded serial length");
		else
			check(n == 2 * nb + 2, "serial length");
		for (int i = 0; i < nb; i++)
		begin
			a = start + 12'(i);
			if (dir)
				check(far.out_mem[a] === bits[i], "out bit");
			else
				check(ser_in_bits[i] === (a[0] ^ a[2]), "in bit");
		end
		check(far.strobes - s0 == (dir ? nb : 0), "strobe count");
		@(negedge sys_clk);
	endtask : ser_run

	task automatic mem_dma();
		int   n;
		logic seen;
		mem_req = '{1'b1, 1'b1, 15'h1234, 16'ha5c3};
		dma_go = 1'b1;
		seen = 1'b0;
		n = 0;
		while (grant !== 1'b1 && n < 50)
		begin
			@(negedge sys_clk);
			dma_go = 1'b0;
			n++;
			if (mcs_n === 1'b0)
				check(addr_out === 15'h1234 && grant === 1'b0 && wr_n === 1'b0
					&& rd === 1'b0 && data_out === 16'ha5c3
					&& data_oe_n === 1'b0, "mem cycle");
			if (mem_done === 1'b1)
			begin
				seen = 1'b1;
				mem_req.valid = 1'b0;
			end
		end
		check(seen === 1'b1, "memory cycle cut");
		check({mcs_oe_n, rd_oe_n, wr_oe_n, addr_oe_n, data_oe_n} === 5'h1f,
			"bus not released");
		n = 0;
		while (dma_busy === 1'b1 && n < 50)
		begin
			@(negedge sys_clk);
			n++;
		end
		check(grant === 1'b0 && addr_oe_n === 1'b0, "bus not resumed");
	endtask : mem_dma

	// ==========================================================
	// Clock, edge discipline of the grant, watchdog, main sequence
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(grant)
		if ($time > 0)
			check(($time % 10) == 5, "grant moved off edge");

	initial
	begin
		#50000;
		miscompares++;
		wrap_up();
	end

	initial
	begin
		rst_n = 1'b0;
		dma_go = 1'b0;
		mem_req = '0;
		ser_req = '0;
		repeat (12) @(negedge sys_clk);
		check(wr_n === 1'b1 && s_strobe === 1'b0 && grant === 1'b0,
			"reset outputs");
		rst_n = 1'b1;
		@(negedge sys_clk);
		ser_run(1'b1, 16'h0148, 8'hfe, 5'h05, 16'h0015, 1'b0);
		ser_run(1'b0, 16'h3ff8, 8'h7f, 5'h00, 16'h0000, 1'b0);
		mem_dma();
		ser_run(1'b1, 16'h0400, 8'h10, 5'h04, 16'h0009, 1'b1);
		wrap_up();
	end
endmodule : ysb_bus_yield_tb
